// File: lcr_consts.svh
/*
  Offsets, reset values, value limits and timing counts of the logger
  configuration register bank. Included by the bank.
*/
`ifndef LCR_CONSTS_SVH
`define LCR_CONSTS_SVH

`define LCR_OFF_DOW        16'h0018
`define LCR_OFF_YEAR       16'h0019
`define LCR_OFF_MONTH      16'h001A
`define LCR_OFF_DAY        16'h001B
`define LCR_OFF_HOUR       16'h001C
`define LCR_OFF_MINUTE     16'h001D
`define LCR_OFF_SECOND     16'h001E
`define LCR_OFF_CLK_CTRL   16'h001F
`define LCR_OFF_NODE_ADDR  16'h0020
`define LCR_OFF_IDENT      16'h0021
`define LCR_OFF_LINE_SPEED 16'h0022
`define LCR_OFF_WR_PERMIT  16'h0023
`define LCR_OFF_FW_VER     16'h0028
`define LCR_OFF_BUILD      16'h0029
`define LCR_OFF_SERIAL_HI  16'h002A
`define LCR_OFF_SERIAL_LO  16'h002B
`define LCR_OFF_CHAN_CNT   16'h002C
`define LCR_OFF_MEM_SIZE   16'h002D
`define LCR_OFF_LOG_DIS    16'h0030
`define LCR_OFF_TRIG_SEL   16'h0031
`define LCR_OFF_REC_INT    16'h0032
`define LCR_OFF_WR_MODE    16'h0033

`define LCR_CTRL_RUN       8'h00
`define LCR_CTRL_LD_TIME   8'h01
`define LCR_CTRL_LD_DATE   8'h02
`define LCR_CTRL_LD_BOTH   8'h03
`define LCR_CTRL_STOP      8'h80

`define LCR_MAX_NODE_ADDR  16'h00C7
`define LCR_MAX_LINE_SPEED 16'h0007
`define LCR_MAX_WR_PERMIT  16'h0001
`define LCR_MAX_LOG_DIS    16'h00FF
`define LCR_MAX_TRIG_SEL   16'h0002
`define LCR_MAX_REC_INT    16'h000E
`define LCR_MAX_WR_MODE    16'h0001
`define LCR_MAX_CTRL_CMD   16'h0003
`define LCR_MIN_YEAR       16'h07D0
`define LCR_MAX_YEAR       16'h0833
`define LCR_MAX_MONTH      16'h000C
`define LCR_MAX_DAY        16'h001F
`define LCR_MAX_HOUR       16'h0017
`define LCR_MAX_MIN_SEC    16'h003B

`define LCR_RST_NODE_ADDR  8'h01
`define LCR_RST_LINE_SPEED 3'h3
`define LCR_RST_WR_PERMIT  1'h1
`define LCR_RST_LOG_DIS    8'h00
`define LCR_RST_TRIG_SEL   2'h0
`define LCR_RST_REC_INT    4'h0
`define LCR_RST_WR_MODE    1'h0

`define LCR_CLK_PERIOD_NS  50
`define LCR_SEC_NS         1000000000
`define LCR_SEC_CYCLES     (`LCR_SEC_NS / `LCR_CLK_PERIOD_NS)

`endif

// File: lcr_pkg.sv
/*
  Types of the logger configuration register bank: the calendar record
  and the register access request. Assumes lcr_consts.svh is on the path.
*/
package lcr_pkg;

  typedef struct packed {
    logic [2:0]  dow;
    logic [15:0] year;
    logic [3:0]  month;
    logic [4:0]  day;
    logic [4:0]  hour;
    logic [5:0]  minute;
    logic [5:0]  second;
  } lcr_cal_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } lcr_req_s;

endpackage

// File: lcr_bank.sv
/*
  Configuration and control holding-register bank of a multi-channel
  logger, with its internal real-time calendar. Assumes a protocol engine
  on the same clock presents one decoded register access per cycle.
*/
`timescale 1ns/1ns
`include "lcr_consts.svh"

module lcr_bank #(
  parameter int          SEC_CYCLES = `LCR_SEC_CYCLES,
  parameter logic [15:0] IDENT_CODE = 16'h5A5A, // Arbitrary value.
  parameter logic [15:0] FW_VERSION = 16'h0001,
  parameter logic [15:0] BUILD_NUM  = 16'h0001,
  parameter logic [31:0] SERIAL_NUM = 32'h0000_0001,
  parameter logic [15:0] CHAN_COUNT = 16'h0008,
  parameter logic [15:0] MEM_KBYTES = 16'h0400
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire lcr_pkg::lcr_req_s req,
  output logic [15:0]           rd_data,
  output logic                  rd_valid,
  output logic [7:0]            node_addr,
  output logic [2:0]            line_speed,
  output logic                  wr_permit,
  output logic [7:0]            log_disable,
  output logic [1:0]            trig_sel,
  output logic [3:0]            rec_interval,
  output logic                  wr_mode,
  output lcr_pkg::lcr_cal_s     rtc_now
);

  logic [7:0]        clk_ctrl;
  lcr_pkg::lcr_cal_s cal;
  logic [31:0]       sec_cnt;
  logic              sec_tick;
  logic              wr_ok;
  logic              cal_wr;
  logic              cmd_wr;
  logic [15:0]       wd;

  // An illegal build-time channel count reads as the full eight-channel unit,
  // so the master never sees a count that the unit cannot have.
  localparam logic [15:0] CHAN_REPORT = (CHAN_COUNT == 16'h0001 || CHAN_COUNT == 16'h0004
                                         || CHAN_COUNT == 16'h0008) ? CHAN_COUNT : 16'h0008;

  // Every fourth year is a leap year, which is exact for 2000 to 2099.
  function automatic logic [4:0] month_days(input logic [15:0] y,
                                            input logic [3:0] m);
    case (m)
      4'h2:    month_days = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'h1E;
      default: month_days = 5'h1F;
    endcase
  endfunction

  function automatic lcr_pkg::lcr_cal_s advance(input lcr_pkg::lcr_cal_s c);
    lcr_pkg::lcr_cal_s n;
    n = c;
    if (c.second != 6'h3B) begin
      n.second = c.second + 6'h01;
    end else begin
      n.second = 6'h00;
      if (c.minute != 6'h3B) begin
        n.minute = c.minute + 6'h01;
      end else begin
        n.minute = 6'h00;
        if (c.hour != 5'h17) begin
          n.hour = c.hour + 5'h01;
        end else begin
          n.hour = 5'h00;
          n.dow  = (c.dow == 3'h6) ? 3'h0 : c.dow + 3'h1;
          if (c.day < month_days(c.year, c.month)) begin
            n.day = c.day + 5'h01;
          end else begin
            n.day = 5'h01;
            if (c.month != 4'hC) begin
              n.month = c.month + 4'h1;
            end else begin
              n.month = 4'h1;
              n.year  = (c.year == `LCR_MAX_YEAR) ? `LCR_MIN_YEAR : c.year + 16'h0001;
            end
          end
        end
      end
    end
    advance = n;
  endfunction

  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // A denied write is dropped before any decode, so no side effect leaks.
  assign wr_ok  = req.wr && wr_permit;
  assign wd     = req.wdata;
  assign cal_wr = wr_ok && (req.addr >= `LCR_OFF_YEAR) && (req.addr <= `LCR_OFF_SECOND);
  assign cmd_wr = wr_ok && (req.addr == `LCR_OFF_CLK_CTRL)
                  && (wd <= `LCR_MAX_CTRL_CMD);

  // One-second enable for the internal clock.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sec_cnt  <= 32'h0000_0000;
      sec_tick <= 1'b0;
    end else if (sec_cnt == 32'(SEC_CYCLES - 1)) begin
      sec_cnt  <= 32'h0000_0000;
      sec_tick <= 1'b1;
    end else begin
      sec_cnt  <= sec_cnt + 32'h0000_0001;
      sec_tick <= 1'b0;
    end
  end

  // Internal clock; a load command wins over the tick of the same cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rtc_now <= '{dow: 3'h6, year: `LCR_MIN_YEAR, month: 4'h1, day: 5'h01,
                   hour: 5'h00, minute: 6'h00, second: 6'h00};
    end else if (cmd_wr && wd[1:0] != 2'h0) begin
      if (wd[0]) begin
        rtc_now.hour   <= cal.hour;
        rtc_now.minute <= cal.minute;
        rtc_now.second <= cal.second;
      end
      if (wd[1]) begin
        rtc_now.dow   <= cal.dow;
        rtc_now.year  <= cal.year;
        rtc_now.month <= cal.month;
        rtc_now.day   <= cal.day;
      end
    end else if (sec_tick) begin
      rtc_now <= advance(rtc_now);
    end
  end

  // Clock control: commands execute at once, so a legal write lands as 0.
  // A calendar write and a command never meet in one cycle, as their addresses differ.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_ctrl <= `LCR_CTRL_RUN;
    end else if (cal_wr) begin
      clk_ctrl <= `LCR_CTRL_STOP;
    end else if (cmd_wr) begin
      clk_ctrl <= `LCR_CTRL_RUN;
    end
  end

  // Calendar registers; out-of-range values are dropped.
  // The copy lags the internal clock by one cycle, a gap the master cannot see.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal <= '{dow: 3'h6, year: `LCR_MIN_YEAR, month: 4'h1, day: 5'h01,
               hour: 5'h00, minute: 6'h00, second: 6'h00};
    end else if (cal_wr) begin
      case (req.addr)
        `LCR_OFF_YEAR: begin
          if (in_range(wd, `LCR_MIN_YEAR, `LCR_MAX_YEAR)) begin
            cal.year <= wd;
          end
        end
        `LCR_OFF_MONTH: begin
          if (in_range(wd, 16'h0001, `LCR_MAX_MONTH)) begin
            cal.month <= wd[3:0];
          end
        end
        `LCR_OFF_DAY: begin
          if (in_range(wd, 16'h0001, `LCR_MAX_DAY)) begin
            cal.day <= wd[4:0];
          end
        end
        `LCR_OFF_HOUR: begin
          if (wd <= `LCR_MAX_HOUR) begin
            cal.hour <= wd[4:0];
          end
        end
        `LCR_OFF_MINUTE: begin
          if (wd <= `LCR_MAX_MIN_SEC) begin
            cal.minute <= wd[5:0];
          end
        end
        `LCR_OFF_SECOND: begin
          if (wd <= `LCR_MAX_MIN_SEC) begin
            cal.second <= wd[5:0];
          end
        end
        default: cal <= cal;
      endcase
    end else if (clk_ctrl == `LCR_CTRL_RUN) begin
      cal <= rtc_now;
    end
  end

  // Port and logging settings; illegal codes leave the old value.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      node_addr    <= `LCR_RST_NODE_ADDR;
      line_speed   <= `LCR_RST_LINE_SPEED;
      wr_permit    <= `LCR_RST_WR_PERMIT;
      log_disable  <= `LCR_RST_LOG_DIS;
      trig_sel     <= `LCR_RST_TRIG_SEL;
      rec_interval <= `LCR_RST_REC_INT;
      wr_mode      <= `LCR_RST_WR_MODE;
    end else if (wr_ok) begin
      case (req.addr)
        `LCR_OFF_NODE_ADDR: begin
          if (wd <= `LCR_MAX_NODE_ADDR) begin
            node_addr <= wd[7:0];
          end
        end
        `LCR_OFF_LINE_SPEED: begin
          if (wd <= `LCR_MAX_LINE_SPEED) begin
            line_speed <= wd[2:0];
          end
        end
        `LCR_OFF_WR_PERMIT: begin
          if (wd <= `LCR_MAX_WR_PERMIT) begin
            wr_permit <= wd[0];
          end
        end
        `LCR_OFF_LOG_DIS: begin
          if (wd <= `LCR_MAX_LOG_DIS) begin
            log_disable <= wd[7:0];
          end
        end
        `LCR_OFF_TRIG_SEL: begin
          if (wd <= `LCR_MAX_TRIG_SEL) begin
            trig_sel <= wd[1:0];
          end
        end
        `LCR_OFF_REC_INT: begin
          if (wd <= `LCR_MAX_REC_INT) begin
            rec_interval <= wd[3:0];
          end
        end
        `LCR_OFF_WR_MODE: begin
          if (wd <= `LCR_MAX_WR_MODE) begin
            wr_mode <= wd[0];
          end
        end
        default: wr_mode <= wr_mode;
      endcase
    end
  end

  // Read port: data one cycle after the request, zero when unmapped.
  // Calendar words come from the registers, not the internal clock, so a frozen
  // calendar shows exactly what the master wrote.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= req.rd;
      if (req.rd) begin
        case (req.addr)
          `LCR_OFF_DOW:        rd_data <= {13'h0000, cal.dow};
          `LCR_OFF_YEAR:       rd_data <= cal.year;
          `LCR_OFF_MONTH:      rd_data <= {12'h000, cal.month};
          `LCR_OFF_DAY:        rd_data <= {11'h000, cal.day};
          `LCR_OFF_HOUR:       rd_data <= {11'h000, cal.hour};
          `LCR_OFF_MINUTE:     rd_data <= {10'h000, cal.minute};
          `LCR_OFF_SECOND:     rd_data <= {10'h000, cal.second};
          `LCR_OFF_CLK_CTRL:   rd_data <= {8'h00, clk_ctrl};
          `LCR_OFF_NODE_ADDR:  rd_data <= {8'h00, node_addr};
          `LCR_OFF_IDENT:      rd_data <= IDENT_CODE;
          `LCR_OFF_LINE_SPEED: rd_data <= {13'h0000, line_speed};
          `LCR_OFF_WR_PERMIT:  rd_data <= {15'h0000, wr_permit};
          `LCR_OFF_FW_VER:     rd_data <= FW_VERSION;
          `LCR_OFF_BUILD:      rd_data <= BUILD_NUM;
          `LCR_OFF_SERIAL_HI:  rd_data <= SERIAL_NUM[31:16];
          `LCR_OFF_SERIAL_LO:  rd_data <= SERIAL_NUM[15:0];
          `LCR_OFF_CHAN_CNT:   rd_data <= CHAN_REPORT;
          `LCR_OFF_MEM_SIZE:   rd_data <= MEM_KBYTES;
          `LCR_OFF_LOG_DIS:    rd_data <= {8'h00, log_disable};
          `LCR_OFF_TRIG_SEL:   rd_data <= {14'h0000, trig_sel};
          `LCR_OFF_REC_INT:    rd_data <= {12'h000, rec_interval};
          `LCR_OFF_WR_MODE:    rd_data <= {15'h0000, wr_mode};
          default:             rd_data <= 16'h0000;
        endcase
      end
    end
  end

endmodule // lcr_bank

// File: lcr_bank_properties.sv
/*
  Concurrent checks on the ports of the logger register bank.
  Assumes the bank's clock and active-low reset, bound from the bench.
*/
`timescale 1ns/1ns
module lcr_bank_checker (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire lcr_pkg::lcr_req_s req,
  input wire logic              rd_valid,
  input wire logic [7:0]        node_addr,
  input wire logic [2:0]        line_speed,
  input wire logic              wr_permit,
  input wire logic [7:0]        log_disable,
  input wire logic [1:0]        trig_sel,
  input wire logic [3:0]        rec_interval
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic ok_wr;
  assign ok_wr = req.wr && wr_permit;

  a_read_pulse: assert property (req.rd ##1 !req.rd |-> rd_valid ##1 !rd_valid)
    else $error("read answer not a single pulse");
  a_no_spurious: assert property (!req.rd |=> !rd_valid)
    else $error("read answer without read");
  a_addr_store: assert property (ok_wr && req.addr == 16'h0020 && req.wdata <= 16'h00C7
    |=> node_addr == $past(req.wdata[7:0]))
    else $error("device address not stored");
  a_addr_limit: assert property (req.wr && req.addr == 16'h0020 && req.wdata > 16'h00C7
    |=> $stable(node_addr))
    else $error("device address above limit stored");
  a_speed_store: assert property (ok_wr && req.addr == 16'h0022 && req.wdata <= 16'h0007
    |=> line_speed == $past(req.wdata[2:0]))
    else $error("line speed not stored");
  a_locked_hold: assert property (!wr_permit |=> $stable(node_addr)
    && $stable(wr_permit) && $stable(log_disable) && $stable(rec_interval))
    else $error("setting changed while writes denied");
  a_chan_store: assert property (ok_wr && req.addr == 16'h0030 && req.wdata <= 16'h00FF
    |=> log_disable == $past(req.wdata[7:0]))
    else $error("channel disable bits not stored");
  a_trig_limit: assert property (req.wr && req.addr == 16'h0031 && req.wdata > 16'h0002
    |=> $stable(trig_sel))
    else $error("trigger code above limit stored");
  a_period_store: assert property (ok_wr && req.addr == 16'h0032 && req.wdata <= 16'h000E
    |=> rec_interval == $past(req.wdata[3:0]))
    else $error("record period not stored");
endmodule // lcr_bank_checker

// File: lcr_host.sv
/*
  Field-bus master model issuing one register access at a time.
  Assumes the bank answers a read with rd_valid one cycle later.
*/
`timescale 1ns/1ns
module lcr_host (
  input  wire logic         clk,
  input  wire logic         rd_valid,
  input  wire logic [15:0]  rd_data,
  output lcr_pkg::lcr_req_s req
);
  initial req = '0;
  task automatic access(input logic w, input logic [15:0] a, d,
                        output logic [15:0] q, output logic ok);
    int n;
    @(posedge clk) #1;
    req = {w, !w, a, d};
    @(posedge clk) #1;
    // Released lines show inverted values so that a stale capture is caught.
    req = {2'b00, ~a, ~d};
    ok = w;
    q = 16'h0000;
    for (n = 0; n < 4 && !ok; n++) begin
      if (rd_valid === 1'b1) begin
        q = rd_data;
        ok = 1'b1;
      end else @(posedge clk) #1;
    end
  endtask
endmodule // lcr_host

// File: logger_config_register_bank_tb.sv
/*
  Self-checking bench of the logger register bank with a master model.
  Assumes the checker and host model files are compiled first.
*/
`timescale 1ns/1ns
module logger_config_register_bank_tb;
  logic clk, rst_b, rd_valid, wr_permit, wr_mode, ok;
  logic [15:0] rd_data, q;
  logic [7:0] node_addr, log_disable;
  logic [2:0] line_speed;
  logic [1:0] trig_sel;
  logic [3:0] rec_interval;
  lcr_pkg::lcr_req_s req;
  lcr_pkg::lcr_cal_s rtc_now;
  int fail_count = 0, checked = 0, seed = 81, i, k, d, s0;
  int m[int];
  int offs[6] = '{'h20, 'h22, 'h30, 'h31, 'h32, 'h33};
  int lim[6] = '{199, 7, 255, 2, 14, 1};
  int ro[7] = '{'h21, 'h28, 'h29, 'h2A, 'h2B, 'h2C, 'h2D};

  // A 20-cycle second lets the calendar run visibly within the test.
  lcr_bank #(.SEC_CYCLES(20), .IDENT_CODE(16'h3C3C), .FW_VERSION(16'h0002),
    .SERIAL_NUM(32'h1234_5678), .CHAN_COUNT(16'h0004)) i_dut (
    .clk(clk), .rst_b(rst_b), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .node_addr(node_addr), .line_speed(line_speed), .wr_permit(wr_permit),
    .log_disable(log_disable), .trig_sel(trig_sel), .rec_interval(rec_interval),
    .wr_mode(wr_mode), .rtc_now(rtc_now));
  lcr_host i_host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .req(req));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input int a, v);
    i_host.access(1'b1, a[15:0], v[15:0], q, ok);
  endtask
  task automatic rd(input int a);
    i_host.access(1'b0, a[15:0], 16'h0000, q, ok);
    if (!ok) begin
      fail_count++;
      final_report();
    end
  endtask
  function automatic logic [15:0] cur(int a);
    case (a)
      'h20: cur = {8'h00, node_addr};
      'h22: cur = {13'h0000, line_speed};
      'h30: cur = {8'h00, log_disable};
      'h31: cur = {14'h0000, trig_sel};
      'h32: cur = {12'h000, rec_interval};
      default: cur = {15'h0000, wr_mode};
    endcase
  endfunction

  initial begin
    rst_b = 1'b0;
    m = '{'h20: 1, 'h22: 3, 'h30: 0, 'h31: 0, 'h32: 0, 'h33: 0, 'h21: 'h3C3C, 'h28: 2,
          'h29: 1, 'h2A: 'h1234, 'h2B: 'h5678, 'h2C: 4, 'h2D: 'h400};
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    for (i = 0; i < 6; i++) chk(cur(offs[i]), m[offs[i]]);
    // Read-only words must survive a write of all ones.
    for (i = 0; i < 7; i++) begin
      wr(ro[i], 'hFFFF);
      rd(ro[i]);
      chk(q, m[ro[i]]);
    end
    // Values up to twice the limit plus one mix accepted and refused writes.
    for (i = 0; i < 60; i++) begin
      k = $unsigned($random(seed)) % 6;
      d = $unsigned($random(seed)) % (2 * lim[k] + 2);
      wr(offs[k], d);
      if (d <= lim[k]) m[offs[k]] = d;
      chk(cur(offs[k]), m[offs[k]]);
      rd(offs[k]);
      chk(q, m[offs[k]]);
    end
    rd('h1F);
    chk(q, 0);
    wr('h1C, 5);
    rd('h1F);
    chk(q, 'h80);
    wr('h1D, 6);
    wr('h1E, 7);
    wr('h1F, 1);
    chk({rtc_now.hour, rtc_now.minute, rtc_now.second}, {5'h05, 6'h06, 6'h07});
    rd('h1F);
    chk(q, 0);
    rd('h1C);
    chk(q, 5);
    wr('h19, 2050);
    wr('h1A, 3);
    wr('h1B, 4);
    wr('h1F, 2);
    chk({rtc_now.year, rtc_now.month, rtc_now.day}, {16'h0802, 4'h3, 5'h04});
    wr('h1C, 1);
    wr('h1F, 3);
    chk({rtc_now.year, rtc_now.hour}, {16'h0802, 5'h01});
    // An out-of-range hour still freezes the calendar but is not stored.
    wr('h1C, 24);
    rd('h1F);
    chk(q, 'h80);
    rd('h1C);
    chk(q, 1);
    wr('h1F, 4);
    rd('h1F);
    chk(q, 'h80);
    wr('h1F, 0);
    rd('h1F);
    chk(q, 0);
    // Two reads 40 cycles apart see exactly two second ticks.
    rd('h1E);
    s0 = q;
    repeat (38) @(posedge clk);
    rd('h1E);
    chk((int'(q) - s0 + 60) % 60, 2);
    wr('h23, 0);
    chk(wr_permit, 1'b0);
    d = (m['h20] + 1) % 200;
    wr('h20, d);
    chk(node_addr, m['h20]);
    wr('h23, 1);
    chk(wr_permit, 1'b0);
    final_report();
  end
endmodule // logger_config_register_bank_tb

bind lcr_bank lcr_bank_checker i_chk (.clk(clk), .rst_b(rst_b), .req(req),
  .rd_valid(rd_valid), .node_addr(node_addr), .line_speed(line_speed),
  .wr_permit(wr_permit), .log_disable(log_disable), .trig_sel(trig_sel),
  .rec_interval(rec_interval));
